// ### pkg/ear_pkg.sv
package ear_pkg;
  localparam int          NUM_PORTS      = 16;
  localparam int          EXP_ADDR_BITS  = 7;
  // register byte offsets
  localparam logic [11:0] OFF_EXP_ADDR2  = 12'hae0;
  localparam logic [11:0] OFF_EXP_ADDR3  = 12'hae4;
  localparam logic [11:0] OFF_EVT_CTL    = 12'hae8;
  localparam logic [11:0] OFF_EVT_STS    = 12'haec;
  // writable bits of each register; everything else is reserved
  localparam logic [31:0] MASK_EXP_ADDR2 = 32'hfefefefe;
  localparam logic [31:0] MASK_EXP_ADDR3 = 32'h0000fefe;
  localparam logic [31:0] MASK_EVT_CTL   = 32'h8000ffff;
  localparam logic [31:0] RESET_VALUE    = 32'h00000000;
  // field positions
  localparam int          POS_EXP_LO     = 1;
  localparam int          POS_EXP_STRIDE = 8;
  localparam int          POS_INVERT     = 31;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ### src/ear_pin_mux.sv
`timescale 1ns/1ps
// alternate-function mux: a routed port takes over its gpio pin for the event output
module ear_pin_mux (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic [ear_pkg::NUM_PORTS-1:0] route_enable,
  input  wire logic [ear_pkg::NUM_PORTS-1:0] route_active,
  input  wire logic                          polarity_invert,
  input  wire logic [ear_pkg::NUM_PORTS-1:0] core_out,
  input  wire logic [ear_pkg::NUM_PORTS-1:0] core_oe,
  output logic      [ear_pkg::NUM_PORTS-1:0] pin_out,
  output logic      [ear_pkg::NUM_PORTS-1:0] pin_oe
);
  typedef struct packed {
    logic [ear_pkg::NUM_PORTS-1:0] out;
    logic [ear_pkg::NUM_PORTS-1:0] oe;
  } ear_mux_s;

  ear_mux_s                      st_reg;
  ear_mux_s                      st_next;
  logic [ear_pkg::NUM_PORTS-1:0] sel_out;
  logic [ear_pkg::NUM_PORTS-1:0] sel_oe;

  genvar g;
  generate
    for (g = 0; g < ear_pkg::NUM_PORTS; g++) begin : g_pin
      // active low unless inverted
      assign sel_out[g] = route_enable[g] ? ~(route_active[g] ^ polarity_invert) : core_out[g];
      assign sel_oe[g]  = route_enable[g] ? 1'b1 : core_oe[g];
    end
  endgenerate

  always_comb begin
    st_next     = st_reg;
    st_next.out = sel_out;
    st_next.oe  = sel_oe;
    if (reset) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  assign pin_out = st_reg.out;
  assign pin_oe  = st_reg.oe;
endmodule

// ### src/ear_top.sv
`timescale 1ns/1ps
module ear_top #(
  parameter int AW = 12
) (
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic [AW-1:0]                     s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [AW-1:0]                     s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [ear_pkg::NUM_PORTS-1:0]     port_event_request,
  output logic [ear_pkg::NUM_PORTS-1:0]          legacy_notify,
  input  wire logic [ear_pkg::NUM_PORTS-1:0]     gpio_core_out,
  input  wire logic [ear_pkg::NUM_PORTS-1:0]     gpio_core_oe,
  output logic [ear_pkg::NUM_PORTS-1:0]          gpio_out,
  output logic [ear_pkg::NUM_PORTS-1:0]          gpio_oe,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_eight_addr,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_nine_addr,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_ten_addr,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_eleven_addr,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_twelve_addr,
  output logic [ear_pkg::EXP_ADDR_BITS-1:0]      expander_thirteen_addr
);
  // the register offsets need twelve address bits; the bus cannot be wider than a word
  generate
    if (AW < 12 || AW > 32) begin : g_bad_aw
      $error("ear_top: AW must be 12 to 32");
    end
  endgenerate

  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    logic                          aw_held;
    logic [AW-1:0]                 aw_addr;
    logic                          w_held;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic [31:0]                   exp_addr2;
    logic [31:0]                   exp_addr3;
    logic [31:0]                   evt_ctl;
    logic [ear_pkg::NUM_PORTS-1:0] active;
    logic [ear_pkg::NUM_PORTS-1:0] legacy;
  } ear_state_s;

  ear_state_s  st_reg;
  ear_state_s  st_next;
  logic        aw_fire;
  logic        w_fire;
  logic        wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // byte-lane merge; reserved bits are forced to zero on every write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r & mask;
  endfunction

  function automatic logic match(input logic [AW-1:0] a, input logic [11:0] off);
    return {a[AW-1:2], 2'h0} == AW'(off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    aw_fire = s_axi_awvalid && st_reg.awready;
    w_fire  = s_axi_wvalid && st_reg.wready;
    wr_addr = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr;
    wr_data = st_reg.w_held ? st_reg.w_data : s_axi_wdata;
    wr_strb = st_reg.w_held ? st_reg.w_strb : s_axi_wstrb;
    wr_en   = (st_reg.aw_held || aw_fire) && (st_reg.w_held || w_fire) && !st_reg.bvalid;

    if (aw_fire) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_en) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ear_pkg::RESP_OKAY;
      if (match(wr_addr, ear_pkg::OFF_EXP_ADDR2)) begin
        st_next.exp_addr2 = merge(st_reg.exp_addr2, wr_data, wr_strb, ear_pkg::MASK_EXP_ADDR2);
      end else if (match(wr_addr, ear_pkg::OFF_EXP_ADDR3)) begin
        st_next.exp_addr3 = merge(st_reg.exp_addr3, wr_data, wr_strb, ear_pkg::MASK_EXP_ADDR3);
      end else if (match(wr_addr, ear_pkg::OFF_EVT_CTL)) begin
        st_next.evt_ctl = merge(st_reg.evt_ctl, wr_data, wr_strb, ear_pkg::MASK_EVT_CTL);
      end else if (!match(wr_addr, ear_pkg::OFF_EVT_STS)) begin
        st_next.bresp = ear_pkg::RESP_SLVERR;
      end
    end
    // one write in flight: no new address or data until the response is gone
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready  = !st_next.w_held && !st_next.bvalid;

    if (s_axi_rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = ear_pkg::RESP_OKAY;
      st_next.rdata   = ear_pkg::RESET_VALUE;
      if (match(s_axi_araddr, ear_pkg::OFF_EXP_ADDR2)) begin
        st_next.rdata = st_reg.exp_addr2;
      end else if (match(s_axi_araddr, ear_pkg::OFF_EXP_ADDR3)) begin
        st_next.rdata = st_reg.exp_addr3;
      end else if (match(s_axi_araddr, ear_pkg::OFF_EVT_CTL)) begin
        st_next.rdata = st_reg.evt_ctl;
      end else if (match(s_axi_araddr, ear_pkg::OFF_EVT_STS)) begin
        st_next.rdata = {16'h0000, st_reg.active};
      end else begin
        st_next.rresp = ear_pkg::RESP_SLVERR;
      end
    end

    // gated with the enable that will stand next cycle, so status never outlives its enable
    st_next.active = port_event_request & st_next.evt_ctl[ear_pkg::NUM_PORTS-1:0];
    st_next.legacy = port_event_request & ~st_next.evt_ctl[ear_pkg::NUM_PORTS-1:0];

    if (reset) begin
      st_next         = '0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
      st_next.arready = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  ear_pin_mux u_pin_mux (
    .clock           (clock),
    .reset           (reset),
    .route_enable    (st_next.evt_ctl[ear_pkg::NUM_PORTS-1:0]),
    .route_active    (st_next.active),
    .polarity_invert (st_next.evt_ctl[ear_pkg::POS_INVERT]),
    .core_out        (gpio_core_out),
    .core_oe         (gpio_core_oe),
    .pin_out         (gpio_out),
    .pin_oe          (gpio_oe)
  );

  assign s_axi_awready          = st_reg.awready;
  assign s_axi_wready           = st_reg.wready;
  assign s_axi_bvalid           = st_reg.bvalid;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = st_reg.arready;
  assign s_axi_rvalid           = st_reg.rvalid;
  assign s_axi_rresp            = st_reg.rresp;
  assign s_axi_rdata            = st_reg.rdata;
  assign legacy_notify          = st_reg.legacy;
  assign expander_eight_addr    = st_reg.exp_addr2[7:1];
  assign expander_nine_addr     = st_reg.exp_addr2[15:9];
  assign expander_ten_addr      = st_reg.exp_addr2[23:17];
  assign expander_eleven_addr   = st_reg.exp_addr2[31:25];
  assign expander_twelve_addr   = st_reg.exp_addr3[7:1];
  assign expander_thirteen_addr = st_reg.exp_addr3[15:9];

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] en_q;
  logic        inv_q;
  logic        wr_a2_full;
  logic        wr_a3_full;
  assign en_q       = st_reg.evt_ctl[15:0];
  assign inv_q      = st_reg.evt_ctl[31];
  assign wr_a2_full = wr_en && match(wr_addr, ear_pkg::OFF_EXP_ADDR2) && (wr_strb == 4'hf);
  assign wr_a3_full = wr_en && match(wr_addr, ear_pkg::OFF_EXP_ADDR3) && (wr_strb == 4'hf);

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_legacy_route;
    ##1 (legacy_notify == ($past(port_event_request) & ~en_q)) && ((legacy_notify & en_q) == 16'h0000);
  endproperty
  a_legacy_route: assert property (p_legacy_route) else $error("legacy path not suppressed");

  property p_pol_low;
    !inv_q |-> ((gpio_out & en_q) == (~st_reg.active & en_q));
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("event pin not active low");

  property p_pol_high;
    inv_q |-> ((gpio_out & en_q) == (st_reg.active & en_q));
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("event pin not active high");

  property p_status_track;
    ##1 st_reg.active == ($past(port_event_request) & en_q);
  endproperty
  a_status_track: assert property (p_status_track) else $error("status does not follow event");

  property p_status_gate;
    (st_reg.active & ~en_q) == 16'h0000;
  endproperty
  a_status_gate: assert property (p_status_gate) else $error("status set for disabled port");

  property p_exp_grp2;
    wr_a2_full |=> (expander_eight_addr == $past(wr_data[7:1])) && (expander_eleven_addr == $past(wr_data[31:25]));
  endproperty
  a_exp_grp2: assert property (p_exp_grp2) else $error("group two address not stored");

  property p_exp_grp3;
    wr_a3_full |=> (expander_thirteen_addr == $past(wr_data[15:9])) && (st_reg.exp_addr3[31:16] == 16'h0000);
  endproperty
  a_exp_grp3: assert property (p_exp_grp3) else $error("group three address wrong");

  property p_pin_alt;
    ##1 (gpio_oe == ($past(gpio_core_oe) | en_q)) && ((gpio_out & ~en_q) == ($past(gpio_core_out) & ~en_q));
  endproperty
  a_pin_alt: assert property (p_pin_alt) else $error("gpio mux wrong");

  property p_reserved_zero;
    ((st_reg.exp_addr2 & ~ear_pkg::MASK_EXP_ADDR2) == 32'h0) && ((st_reg.evt_ctl & ~ear_pkg::MASK_EVT_CTL) == 32'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_bvalid_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

  c_write:  cover property (wr_en ##1 s_axi_bvalid);
  c_read:   cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
  c_routed: cover property (|(st_reg.active) && !inv_q);
  c_invert: cover property (|(st_reg.active) && inv_q);
endmodule

// ### tb/ear_event_sink.sv
`timescale 1ns/1ps
// system logic watching the event pins: decodes a driven pin at the configured polarity
module ear_event_sink (
  input  wire logic        clock,
  input  wire logic        polarity_invert,
  input  wire logic [15:0] route_mask,
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] gpio_oe,
  output logic      [15:0] event_seen
);
  // an undriven pin counts as idle, never as an event
  // a pin left in its normal gpio function is not an event pin, whatever level it shows
  always_ff @(posedge clock) begin
    event_seen <= route_mask & gpio_oe & ~(gpio_out ^ {16{polarity_invert}});
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 0, reset = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] req = 0, core_out = 0, core_oe = 0, legacy, gout, goe, seen, act;
  logic [6:0] e8, e9, e10, e11, e12, e13;
  int fail_count = 0, num_checks = 0, cycles = 0, seed = 7452;
  int mdl [4];
  logic [31:0] msk [4] = '{ear_pkg::MASK_EXP_ADDR2, ear_pkg::MASK_EXP_ADDR3, ear_pkg::MASK_EVT_CTL, 32'h0};
  ear_top i_ear_top (.clock(clock), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_event_request(req),
    .legacy_notify(legacy), .gpio_core_out(core_out), .gpio_core_oe(core_oe), .gpio_out(gout),
    .gpio_oe(goe), .expander_eight_addr(e8), .expander_nine_addr(e9), .expander_ten_addr(e10),
    .expander_eleven_addr(e11), .expander_twelve_addr(e12), .expander_thirteen_addr(e13));
  ear_event_sink i_ear_event_sink (.clock(clock), .polarity_invert(mdl[2][31]), .route_mask(mdl[2][15:0]), .gpio_out(gout),
    .gpio_oe(goe), .event_seen(seen));
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // readies only move at rising edges, so the value at the falling edge is what the next edge samples
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit a_ok, w_ok, done;
    done = 0;
    @(posedge clock);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!done) begin
      @(negedge clock);
      a_ok = awready && awvalid;
      w_ok = wready && wvalid;
      done = bvalid;
      r = bresp;
      @(posedge clock);
      if (a_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
      if (done) bready <= 0;
    end
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit a_ok, done;
    done = 0;
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!done) begin
      @(negedge clock);
      a_ok = arready && arvalid;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (a_ok) arvalid <= 0;
      if (done) rready <= 0;
    end
  endtask
  task automatic mdl_write(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] lanes;
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    mdl[i] = ((mdl[i] & ~lanes) | (d & lanes)) & msk[i];
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [3:0] s;
    logic [11:0] a;
    mdl = '{0, 0, 0, 0};
    repeat (8) @(posedge clock);
    reset <= 0;
    for (int i = 0; i < 4; i++) begin
      axi_read(ear_pkg::OFF_EXP_ADDR2 + 12'(4 * i), rd, rs);
      check("reset value", 32'h0, rd);
    end
    // register writes with random data and lanes, then read-back and field outputs
    for (int k = 0; k < 12; k++) begin
      d = $random(seed);
      s = (k < 3) ? 4'hf : 4'($random(seed));
      a = ear_pkg::OFF_EXP_ADDR2 + 12'(4 * (k % 3));
      axi_write(a, d, s, rs);
      mdl_write(k % 3, d, s);
      check("bresp", ear_pkg::RESP_OKAY, 32'(rs));
      axi_read(a, rd, rs);
      check("readback", mdl[k % 3], rd);
      check("e8", mdl[0][7:1], 32'(e8));
      check("e9", mdl[0][15:9], 32'(e9));
      check("e10", mdl[0][23:17], 32'(e10));
      check("e11", mdl[0][31:25], 32'(e11));
      check("e12", mdl[1][7:1], 32'(e12));
      check("e13", mdl[1][15:9], 32'(e13));
    end
    // unmapped places and the read-only status word
    for (int j = 0; j < 2; j++) begin
      a = (j != 0) ? 12'h000 : 12'haf0;
      axi_write(a, 32'hffffffff, 4'hf, rs);
      check("unmapped bresp", ear_pkg::RESP_SLVERR, 32'(rs));
      axi_read(a, rd, rs);
      check("unmapped rresp", ear_pkg::RESP_SLVERR, 32'(rs));
      check("unmapped rdata", 32'h0, rd);
    end
    axi_write(ear_pkg::OFF_EVT_STS, 32'hffffffff, 4'hf, rs);
    check("status bresp", ear_pkg::RESP_OKAY, 32'(rs));
    axi_read(ear_pkg::OFF_EVT_STS, rd, rs);
    check("status write ignored", 32'h0, rd);
    // random requests against random routing and polarity
    for (int k = 0; k < 200; k++) begin
      if (k % 25 == 0) begin
        d = $random(seed);
        axi_write(ear_pkg::OFF_EVT_CTL, d, 4'hf, rs);
        mdl_write(2, d, 4'hf);
      end
      @(posedge clock);
      req <= 16'($random(seed));
      core_out <= 16'($random(seed));
      core_oe <= 16'($random(seed));
      @(posedge clock);
      @(negedge clock);
      act = {16{mdl[2][31]}};
      check("legacy", 32'(req & ~mdl[2][15:0]), 32'(legacy));
      check("gpio_oe", 32'(mdl[2][15:0] | core_oe), 32'(goe));
      check("gpio_out", 32'((mdl[2][15:0] & ~(req ^ act)) | (~mdl[2][15:0] & core_out)), 32'(gout));
      @(negedge clock);
      check("event seen", 32'(req & mdl[2][15:0]), 32'(seen));
      if (k % 10 == 0) begin
        axi_read(ear_pkg::OFF_EVT_STS, rd, rs);
        check("status", 32'(req & mdl[2][15:0]), rd);
      end
    end
    print_verdict();
  end
endmodule
